//--- hw/tcic_pkg.sv
/*
 * Constants shared by the capture input conditioning block: register
 * offsets, field positions, reset values and capture source mode codes.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tcic_pkg;
	// Register offsets (byte addresses)
	localparam logic [7:0] TCIC_PAIR01_OFS = 8'h18;
	localparam logic [7:0] TCIC_PAIR23_OFS = 8'h1C;
	localparam logic [15:0] TCIC_PAIR01_RST = 16'h0000;
	localparam logic [15:0] TCIC_PAIR23_RST = 16'h0000;
	localparam int TCIC_REG_W = 16;
	// Field positions inside a pair register (low and high channel)
	localparam int TCIC_LO_MODE_POS = 0;
	localparam int TCIC_LO_DIV_POS = 2;
	localparam int TCIC_LO_FLT_POS = 4;
	localparam int TCIC_HI_MODE_POS = 8;
	localparam int TCIC_HI_DIV_POS = 10;
	localparam int TCIC_HI_FLT_POS = 12;
	localparam int TCIC_CH_NUM = 4;
	localparam int TCIC_PRE_W = 5;
	localparam int TCIC_DTS_DIV = 1;

	typedef enum logic [1:0] {
		TCIC_MODE_OUT = 2'b00,
		TCIC_MODE_OWN = 2'b01,
		TCIC_MODE_NEIGH = 2'b10,
		TCIC_MODE_TRIG = 2'b11
	} tcic_mode_e;
endpackage : tcic_pkg

//--- hw/tcic_cond.sv
/*
 * Capture input conditioning for four timer channels: pin synchroniser,
 * digital noise filter, capture source select and edge prescaler, plus
 * the two channel-pair control registers.
 * Assumes the channel enable bits and the internal trigger come from
 * timer logic on the same clock; capture pins are asynchronous.
 */
`timescale 1ns/10ps

module tcic_cond import tcic_pkg::*; #(
	parameter int DTS_DIV = TCIC_DTS_DIV
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	// Register port
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_wdata_in,
	output logic [31:0] reg_rdata_out,
	// Timer side
	input wire logic [3:0] chan_enable_bit_in,
	input wire logic [3:0] internal_trigger_select_in,
	// Capture pins
	input wire logic [3:0] chan_raw_input_in,
	// Conditioned results
	output logic [3:0] chan_filtered_out,
	output logic [3:0] chan_capture_out
);
	function automatic logic [3:0] filt_n(input logic [3:0] code);
		case (code)
			4'h0: filt_n = 4'h1;
			4'h1: filt_n = 4'h2;
			4'h2: filt_n = 4'h4;
			4'h4, 4'h6, 4'h8, 4'hB, 4'hE: filt_n = 4'h6;
			4'hA, 4'hD: filt_n = 4'h5;
			default: filt_n = 4'h8;
		endcase
	endfunction

	// Sample strobe: kernel rate, or dead-time tick thinned by a power of two
	function automatic logic samp_sel(input logic [3:0] code,
		input logic tick, input logic [TCIC_PRE_W-1:0] pre);
		case (code)
			4'h0: samp_sel = tick;
			4'h1, 4'h2, 4'h3: samp_sel = 1'b1;
			4'h4, 4'h5: samp_sel = tick && (pre[0] == 1'b0);
			4'h6, 4'h7: samp_sel = tick && (pre[1:0] == 2'h0);
			4'h8, 4'h9: samp_sel = tick && (pre[2:0] == 3'h0);
			4'hA, 4'hB, 4'hC: samp_sel = tick && (pre[3:0] == 4'h0);
			default: samp_sel = tick && (pre == 5'h00);
		endcase
	endfunction

	function automatic logic [2:0] div_last(input logic [1:0] code);
		case (code)
			2'h0: div_last = 3'h0;
			2'h1: div_last = 3'h1;
			2'h2: div_last = 3'h3;
			default: div_last = 3'h7;
		endcase
	endfunction

	logic [15:0] pair01;
	logic [15:0] pair23;
	logic [7:0] dts_cnt;
	logic dts_tick;
	logic [TCIC_PRE_W-1:0] pre_cnt;
	logic [3:0] sync1;
	logic [3:0] sync2;
	logic [2:0] flt_cnt [TCIC_CH_NUM];
	logic [3:0] src_prev;
	logic [2:0] psc_cnt [TCIC_CH_NUM];
	logic [3:0] flt_code [TCIC_CH_NUM];
	logic [1:0] div_code [TCIC_CH_NUM];
	logic [1:0] mode [TCIC_CH_NUM];
	logic [3:0] samp;
	logic [3:0] src;
	logic [3:0] edge_hit;
	logic [15:0] next_pair01;
	logic [15:0] next_pair23;

	// Field extraction per channel
	always_comb begin
		flt_code[0] = pair01[TCIC_LO_FLT_POS +: 4];
		div_code[0] = pair01[TCIC_LO_DIV_POS +: 2];
		mode[0] = pair01[TCIC_LO_MODE_POS +: 2];
		flt_code[1] = pair01[TCIC_HI_FLT_POS +: 4];
		div_code[1] = pair01[TCIC_HI_DIV_POS +: 2];
		mode[1] = pair01[TCIC_HI_MODE_POS +: 2];
		flt_code[2] = pair23[TCIC_LO_FLT_POS +: 4];
		div_code[2] = pair23[TCIC_LO_DIV_POS +: 2];
		mode[2] = pair23[TCIC_LO_MODE_POS +: 2];
		flt_code[3] = pair23[TCIC_HI_FLT_POS +: 4];
		div_code[3] = pair23[TCIC_HI_DIV_POS +: 2];
		mode[3] = pair23[TCIC_HI_MODE_POS +: 2];
	end

	// Mode fields keep their value while the channel is enabled
	always_comb begin
		next_pair01 = reg_wdata_in[15:0];
		next_pair23 = reg_wdata_in[15:0];
		if (chan_enable_bit_in[0])
			next_pair01[TCIC_LO_MODE_POS +: 2] = mode[0];
		if (chan_enable_bit_in[1])
			next_pair01[TCIC_HI_MODE_POS +: 2] = mode[1];
		if (chan_enable_bit_in[2])
			next_pair23[TCIC_LO_MODE_POS +: 2] = mode[2];
		if (chan_enable_bit_in[3])
			next_pair23[TCIC_HI_MODE_POS +: 2] = mode[3];
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pair01 <= TCIC_PAIR01_RST;
			pair23 <= TCIC_PAIR23_RST;
		end else if (reg_wr_in) begin
			if (reg_addr_in == TCIC_PAIR01_OFS)
				pair01 <= next_pair01;
			if (reg_addr_in == TCIC_PAIR23_OFS)
				pair23 <= next_pair23;
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			reg_rdata_out <= 32'h0000_0000;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				TCIC_PAIR01_OFS: reg_rdata_out <= {16'h0000, pair01};
				TCIC_PAIR23_OFS: reg_rdata_out <= {16'h0000, pair23};
				default: reg_rdata_out <= 32'h0000_0000;
			endcase
		end
	end

	// Dead-time tick and the sampling prescale counter
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			dts_cnt <= 8'h00;
			pre_cnt <= '0;
		end else if (dts_cnt == 8'(DTS_DIV - 1)) begin
			dts_cnt <= 8'h00;
			pre_cnt <= pre_cnt + 1'b1;
		end else begin
			dts_cnt <= dts_cnt + 1'b1;
		end
	end
	assign dts_tick = (dts_cnt == 8'(DTS_DIV - 1));

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
		end else begin
			sync1 <= chan_raw_input_in;
			sync2 <= sync1;
		end
	end

	always_comb begin
		for (int i = 0; i < TCIC_CH_NUM; i++) begin
			samp[i] = samp_sel(flt_code[i], dts_tick, pre_cnt);
		end
	end

	// Noise filter: consecutive differing samples are counted
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			chan_filtered_out <= 4'h0;
			for (int i = 0; i < TCIC_CH_NUM; i++)
				flt_cnt[i] <= 3'h0;
		end else begin
			for (int i = 0; i < TCIC_CH_NUM; i++) begin
				if (samp[i]) begin
					if (sync2[i] == chan_filtered_out[i]) begin
						flt_cnt[i] <= 3'h0;
					end else if ({1'b0, flt_cnt[i]} ==
						filt_n(flt_code[i]) - 4'h1) begin
						chan_filtered_out[i] <= sync2[i];
						flt_cnt[i] <= 3'h0;
					end else begin
						flt_cnt[i] <= flt_cnt[i] + 3'h1;
					end
				end
			end
		end
	end

	// Capture source per channel; neighbour is the other of the pair
	always_comb begin
		for (int i = 0; i < TCIC_CH_NUM; i++) begin
			case (mode[i])
				TCIC_MODE_OWN: src[i] = chan_filtered_out[i];
				TCIC_MODE_NEIGH: src[i] = chan_filtered_out[i ^ 1];
				TCIC_MODE_TRIG: src[i] = internal_trigger_select_in[i];
				default: src[i] = 1'b0;
			endcase
			edge_hit[i] = src[i] && !src_prev[i] && chan_enable_bit_in[i]
				&& (mode[i] != TCIC_MODE_OUT);
		end
	end

	// Edge prescaler, cleared while the channel is disabled
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			src_prev <= 4'h0;
			chan_capture_out <= 4'h0;
			for (int i = 0; i < TCIC_CH_NUM; i++)
				psc_cnt[i] <= 3'h0;
		end else begin
			src_prev <= src;
			for (int i = 0; i < TCIC_CH_NUM; i++) begin
				chan_capture_out[i] <= 1'b0;
				if (!chan_enable_bit_in[i]) begin
					psc_cnt[i] <= 3'h0;
				end else if (edge_hit[i]) begin
					if (psc_cnt[i] >= div_last(div_code[i])) begin
						psc_cnt[i] <= 3'h0;
						chan_capture_out[i] <= 1'b1;
					end else begin
						psc_cnt[i] <= psc_cnt[i] + 3'h1;
					end
				end
			end
		end
	end

	// Checks, mostly on channel 0
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!arst_n_in);

	filt_count_a: assert property (
		$changed(chan_filtered_out[0]) |->
		{1'b0, $past(flt_cnt[0])} == filt_n($past(flt_code[0])) - 4'h1)
		else $error("filter moved before N events");
	filt_pass_a: assert property (
		flt_code[0] == 4'h0 && samp[0] && sync2[0] != chan_filtered_out[0]
		|=> chan_filtered_out[0] == $past(sync2[0]))
		else $error("unfiltered level did not pass");
	kclk_rate_a: assert property (
		flt_code[0] inside {4'h1, 4'h2, 4'h3} |-> samp[0])
		else $error("kernel rate sample missing");
	dts_rate_a: assert property (
		samp[0] && flt_code[0] >= 4'h4 |-> dts_tick && pre_cnt[0] == 1'b0)
		else $error("slow sample off the divided tick");
	filt_restart_a: assert property (
		samp[0] && sync2[0] == chan_filtered_out[0] |=> flt_cnt[0] == 3'h0)
		else $error("matching sample kept the count");
	psc_clear_a: assert property (
		!chan_enable_bit_in[0] |=> psc_cnt[0] == 3'h0 && !chan_capture_out[0])
		else $error("prescaler not cleared");
	psc_bypass_a: assert property (
		edge_hit[0] && div_code[0] == 2'h0 |=> chan_capture_out[0])
		else $error("edge without capture in bypass");
	psc_div_a: assert property (
		edge_hit[1] && psc_cnt[1] < div_last(div_code[1])
		|=> !chan_capture_out[1])
		else $error("capture before edge count reached");
	cap_pulse_a: assert property (
		chan_capture_out[1] |=> !chan_capture_out[1])
		else $error("capture pulse longer than one cycle");
	mode_lock_a: assert property (
		chan_enable_bit_in[0] && $past(chan_enable_bit_in[0])
		|-> $stable(mode[0]))
		else $error("mode changed while enabled");
	src_neigh_a: assert property (
		mode[3] == TCIC_MODE_NEIGH |-> src[3] == chan_filtered_out[2])
		else $error("neighbour input not routed");
	src_trig_a: assert property (
		mode[2] == TCIC_MODE_TRIG |-> src[2] == internal_trigger_select_in[2])
		else $error("trigger input not routed");
	out_nocap_a: assert property (
		mode[0] == TCIC_MODE_OUT |=> !chan_capture_out[0])
		else $error("capture while channel is an output");

	filt_slow_c: cover property (
		flt_code[0] == 4'hF ##1 $changed(chan_filtered_out[0]));
	filt_fast_c: cover property (
		flt_code[0] == 4'h1 ##1 $changed(chan_filtered_out[0]));
	div8_cap_c: cover property (div_code[1] == 2'h3 && chan_capture_out[1]);
	trig_cap_c: cover property (
		mode[2] == TCIC_MODE_TRIG && chan_capture_out[2]);
	neigh_cap_c: cover property (
		mode[3] == TCIC_MODE_NEIGH && chan_capture_out[3]);
endmodule // tcic_cond

//--- test/tcic_pin_model.sv
/*
 * Capture pin model: drives the four pins to the levels asked for.
 * Assumes the bench changes requests at falling edges; pins then move
 * off-edge, as asynchronous sources do.
 */
`timescale 1ns/10ps
module tcic_pin_model (
	// Clock
	input wire logic ref_clk_in,
	// Requested levels
	input wire logic [3:0] level_in,
	// Capture pins
	output logic [3:0] pin_out
);
	// Pins settle 13 ns after the kernel edge, well clear of sampling
	always @(posedge ref_clk_in) begin
		pin_out <= #13 level_in;
	end
endmodule // tcic_pin_model

//--- test/tcic_tb.sv
/*
 * Bench for tcic_cond: registers, filter codes, prescaler, sources.
 * Assumes tcic_pkg, tcic_cond and tcic_pin_model are compiled first.
 */
`timescale 1ns/10ps
module testbench import tcic_pkg::*; ();
	logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rv;
	logic [3:0] en = 4'h0, trig = 4'h0, lvl = 4'h0, pin, filt, cap;
	logic [31:0] cnt [4] = '{default: 32'h0};
	int error_cnt = 0, n_compared = 0, cyc = 0;
	always #50 clk = ~clk;
	tcic_pin_model PINS (.ref_clk_in(clk), .level_in(lvl), .pin_out(pin));
	tcic_cond #(.DTS_DIV(2)) DUT (.ref_clk_in(clk), .arst_n_in(rst_n),
		.reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_wdata_in(wdata), .reg_rdata_out(rdata),
		.chan_enable_bit_in(en), .internal_trigger_select_in(trig),
		.chan_raw_input_in(pin), .chan_filtered_out(filt),
		.chan_capture_out(cap));
	// Capture pulse tally and hang guard
	always @(posedge clk) begin
		for (int i = 0; i < 4; i++)
			cnt[i] <= cnt[i] + cap[i];
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			error_cnt++;
			conclude();
		end
	end
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wr_reg(logic [7:0] a, logic [31:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask
	task automatic rd_reg(logic [7:0] a);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		@(negedge clk);
		rv = rdata;
	endtask
	task automatic pulses(int ch, int n, int hi, int lo, bit t);
		repeat (n) begin
			{trig[ch], lvl[ch]} = t ? 2'b10 : 2'b01;
			tick(hi);
			{trig[ch], lvl[ch]} = 2'b00;
			tick(lo);
		end
	endtask
	// Kernel cycles per filter sample, dead-time tick being 2 cycles
	function automatic int rate(logic [3:0] c);
		case (c)
			0: return 2;
			1, 2, 3: return 1;
			4, 5: return 4;
			6, 7: return 8;
			8, 9: return 16;
			10, 11, 12: return 32;
			default: return 64;
		endcase
	endfunction
	function automatic int taps(logic [3:0] c);
		case (c)
			0: return 1;
			1: return 2;
			2: return 4;
			4, 6, 8, 11, 14: return 6;
			10, 13: return 5;
			default: return 8;
		endcase
	endfunction
	task automatic t_regs();
		rd_reg(TCIC_PAIR01_OFS);
		check("pair01 reset", rv, 32'h0);
		rd_reg(TCIC_PAIR23_OFS);
		check("pair23 reset", rv, 32'h0);
		wr_reg(TCIC_PAIR23_OFS, 32'hFFFF_A5C3);
		rd_reg(TCIC_PAIR23_OFS);
		check("pair23 rw", rv, 32'h0000_A5C3);
		wr_reg(8'h20, 32'h1234);
		rd_reg(8'h20);
		check("unmapped", rv, 32'h0);
		$display("test regs done");
	endtask
	task automatic t_filter();
		int r, n, l;
		logic [31:0] c0;
		for (int c = 0; c < 16; c++) begin
			r = rate(c);
			n = taps(c);
			l = (n + 1) * r + 3;
			wr_reg(TCIC_PAIR01_OFS, (c == 0 ? 32'h1 : 32'h2) |
				(c << TCIC_LO_FLT_POS));
			en[0] = 1'b1;
			c0 = cnt[0];
			if (n > 1)
				pulses(0, 1, (n - 1) * r, l, 1'b0);
			check("short", cnt[0] - c0, 32'h0);
			lvl[0] = 1'b1;
			tick(l);
			check("rise", filt[0], 32'h1);
			lvl[0] = 1'b0;
			tick(l);
			check("fall", filt[0], 32'h0);
			check("one cap", cnt[0] - c0, 32'h1);
		end
		en[0] = 1'b0;
		$display("test filter done");
	endtask
	task automatic t_presc();
		logic [31:0] c1;
		for (int k = 0; k < 4; k++) begin
			en[1] = 1'b0;
			wr_reg(TCIC_PAIR01_OFS, 32'h100 | (k << TCIC_HI_DIV_POS));
			en[1] = 1'b1;
			c1 = cnt[1];
			pulses(1, 8, 5, 5, 1'b0);
			check("divided", cnt[1] - c1, 32'h8 >> k);
		end
		c1 = cnt[1];
		pulses(1, 5, 5, 5, 1'b0);
		en[1] = 1'b0;
		tick(2);
		en[1] = 1'b1;
		pulses(1, 7, 5, 5, 1'b0);
		check("cleared", cnt[1] - c1, 32'h0);
		pulses(1, 1, 5, 5, 1'b0);
		check("eighth", cnt[1] - c1, 32'h1);
		$display("test prescaler done");
	endtask
	task automatic t_source();
		logic [31:0] c2, c3;
		wr_reg(TCIC_PAIR23_OFS, 32'h0203);
		en[3:2] = 2'b11;
		c2 = cnt[2];
		c3 = cnt[3];
		pulses(2, 3, 2, 3, 1'b1);
		check("trig", cnt[2] - c2, 32'h3);
		pulses(2, 2, 5, 5, 1'b0);
		check("neigh", cnt[3] - c3, 32'h2);
		check("trig only", cnt[2] - c2, 32'h3);
		wr_reg(TCIC_PAIR23_OFS, 32'h0200);
		rd_reg(TCIC_PAIR23_OFS);
		check("mode kept", rv, 32'h0203);
		en[2] = 1'b0;
		wr_reg(TCIC_PAIR23_OFS, 32'h0200);
		en[2] = 1'b1;
		rd_reg(TCIC_PAIR23_OFS);
		check("mode out", rv, 32'h0200);
		c2 = cnt[2];
		pulses(2, 2, 2, 3, 1'b1);
		check("output", cnt[2] - c2, 32'h0);
		$display("test source done");
	endtask
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		tick(4);
		rst_n = 1'b1;
		t_regs();
		t_filter();
		t_presc();
		t_source();
		conclude();
	end
endmodule // testbench
